/* File: rtl/fault_check_pkg.sv */
// shared types and constants for the legacy second-stage fault checker
`default_nettype none
package fault_check_pkg;

   // request categories seen at the remapping unit
   typedef enum logic [1:0] {
      REQ_UNTRANSLATED,
      REQ_TRANSLATION,
      REQ_TRANSLATED
   } req_kind_e;

   // completion status chosen for a request
   typedef enum logic [1:0] {
      RESP_SUCCESS,
      RESP_UR,
      RESP_CA
   } resp_e;

   localparam int ADDR_W = 64;
   localparam int WIDTH_W = 7;

   // one request, with the walk results already gathered upstream
   typedef struct packed {
      req_kind_e           kind;
      logic                has_pasid;
      logic                is_read;
      logic                is_write;
      logic                is_atomic;
      logic                zero_length;
      logic [1:0]          translation_type_field;
      logic [WIDTH_W-1:0]  context_address_width_field;
      logic                entry_rsvd_nonzero;
      logic                entry_read;
      logic                entry_write;
      logic [ADDR_W-1:0]   addr;
      logic [ADDR_W-1:0]   remap_addr;
      logic [15:0]         req_id;
   } req_s;

   // completion plus fault record, issued together
   typedef struct packed {
      resp_e               resp;
      logic                perm_read;
      logic                perm_write;
      logic                fault;
      logic [7:0]          reason;
      logic [15:0]         req_id;
   } cpl_s;

   // fault reason codes
   localparam logic [7:0] REASON_NONE     = 8'h00;
   localparam logic [7:0] REASON_OVERFLOW = 8'h04;
   localparam logic [7:0] REASON_NO_WRITE = 8'h05;
   localparam logic [7:0] REASON_NO_READ  = 8'h06;
   localparam logic [7:0] REASON_RSVD     = 8'h0c;
   localparam logic [7:0] REASON_INTR     = 8'h0e;
   localparam logic [7:0] REASON_ROOT_TBL = 8'h30;

   // mode encodings
   localparam logic [1:0] TTM_LEGACY = 2'h0;
   localparam logic [1:0] TT_PASS    = 2'h2;

   // interrupt window FEEx_xxxx
   localparam int INTR_LSB = 20;
   localparam logic [ADDR_W-INTR_LSB-1:0] INTR_TAG = 44'h00000000fee;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h08;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h0c;
   localparam logic [7:0] OFS_LAST      = 8'h10;
   localparam logic [7:0] OFS_COUNT     = 8'h14;
   localparam logic [7:0] OFS_LOG_IDX   = 8'h18;
   localparam logic [7:0] OFS_LOG_DATA  = 8'h1c;

   // control and last-fault register fields
   localparam int CTRL_TTM_LSB  = 0;
   localparam int CTRL_ZLR_BIT  = 2;
   localparam int CTRL_MAX_GUEST_ADDRESS_WIDTH_LSB = 8;
   localparam int CTRL_HAW_LSB  = 16;
   localparam int LAST_ID_LSB   = 16;

   // interrupt status bits
   localparam int IRQ_W      = 3;
   localparam int IRQ_FAULT  = 0;
   localparam int IRQ_UR     = 1;
   localparam int IRQ_CA     = 2;

   // reset values
   localparam logic [WIDTH_W-1:0] MAX_GUEST_ADDRESS_WIDTH_RESET = 7'h30;
   localparam logic [WIDTH_W-1:0] HAW_RESET  = 7'h30;

endpackage : fault_check_pkg
`default_nettype wire

/* File: rtl/fault_log_mem.sv */
// small fault log memory with registered read data
`default_nettype none
module fault_log_mem #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 24,
   parameter int AW    = $clog2(DEPTH)
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // write port
   input  wire logic             wr_en_i,
   input  wire logic [AW-1:0]    wr_addr_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // read port
   input  wire logic [AW-1:0]    rd_addr_i,
   output logic      [WIDTH-1:0] rd_data_o
);

   logic [WIDTH-1:0] mem [DEPTH];

   // storage has no reset, so it maps onto plain ram
   always_ff @(posedge clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read data
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rd_data_o <= '0;
      end
      else
      begin
         rd_data_o <= mem[rd_addr_i];
      end
   end

endmodule // fault_log_mem
`default_nettype wire

/* File: rtl/legacy_second_stage_fault_checker.sv */
// legacy-mode second-stage fault classifier with wishbone registers
//
// The register addresses and register access over Wishbone are this design's own decisions.
`default_nettype none
module legacy_second_stage_fault_checker #(
   parameter int   LOG_DEPTH = 16,
   parameter logic ZLR_CAP   = 1'b1
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    reset_n_i,
   // request in
   input  wire logic                    req_valid_i,
   input  wire fault_check_pkg::req_s   req_i,
   // completion and fault record out
   output logic                         cpl_valid_o,
   output fault_check_pkg::cpl_s        cpl_o,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // interrupt
   output logic                         irq_o
);

   localparam int LOG_AW = $clog2(LOG_DEPTH);
   localparam int LOG_W  = 24;
   localparam int W      = fault_check_pkg::WIDTH_W;

   typedef struct packed {
      logic                ack;
      logic [31:0]         dat;
      logic [1:0]          translation_table_mode;
      logic [W-1:0]        max_guest_address_width;
      logic [W-1:0]        host_address_width;
      logic [2:0]          irq_stat;
      logic [2:0]          irq_en;
      logic [7:0]          last_reason;
      logic [15:0]         last_id;
      logic [15:0]         fault_cnt;
      logic [LOG_AW-1:0]   log_head;
      logic [LOG_AW-1:0]   log_idx;
      logic                cpl_valid;
      fault_check_pkg::cpl_s cpl;
   } state_s;

   state_s state_reg;
   state_s state_next;

   logic [LOG_W-1:0] log_rd_data;
   logic             log_wr;

   // true when addr does not fit in width bits
   function automatic logic above_width(input logic [63:0] a, input logic [W-1:0] w);
      above_width = (w < 7'd64) ? |(a >> w) : 1'b0;
   endfunction

   // interrupt window test
   function automatic logic in_intr(input logic [63:0] a);
      in_intr = (a[63:fault_check_pkg::INTR_LSB] == fault_check_pkg::INTR_TAG);
   endfunction

   // byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      for (int i = 0; i < 4; i++)
      begin
         merge[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // classification signals
   logic              legacy;
   logic              applicable;
   logic              pass;
   logic              walked;
   logic [W-1:0]      guest_w;
   logic              ovf;
   logic              rsvd;
   logic              wfault;
   logic              rfault;
   logic              zlr_excuse;
   logic              intr;
   logic [63:0]       out_addr;
   logic [7:0]        reason;
   fault_check_pkg::cpl_s cpl_new;

   // fault detection, fixed priority: root mode, overflow, reserved, write, read, interrupt
   always_comb
   begin
      legacy = (state_reg.translation_table_mode == fault_check_pkg::TTM_LEGACY);
      applicable = !req_i.has_pasid || (req_i.kind == fault_check_pkg::REQ_TRANSLATED);
      pass = (req_i.kind == fault_check_pkg::REQ_UNTRANSLATED)
             && (req_i.translation_type_field == fault_check_pkg::TT_PASS);
      walked = (req_i.kind != fault_check_pkg::REQ_TRANSLATED) && !pass;
      guest_w = (state_reg.max_guest_address_width < req_i.context_address_width_field)
                ? state_reg.max_guest_address_width : req_i.context_address_width_field;
      // guest width bound on walked requests
      // host width bound on translated and pass-through requests
      ovf = walked ? above_width(req_i.addr, guest_w) : above_width(req_i.addr, state_reg.host_address_width);
      // reserved field with r or w set
      rsvd = walked && req_i.entry_rsvd_nonzero && (req_i.entry_read || req_i.entry_write);
      // write or atomic without write right
      wfault = walked && (req_i.is_write || req_i.is_atomic) && !req_i.entry_write;
      zlr_excuse = ZLR_CAP && req_i.zero_length && req_i.is_read && !req_i.is_atomic
                   && req_i.entry_write && !req_i.entry_read;
      // read or atomic without read right
      rfault = walked && (req_i.is_read || req_i.is_atomic) && !req_i.entry_read && !zlr_excuse;
      // output address is the remapped address on walked requests, the request address otherwise
      out_addr = walked ? req_i.remap_addr : req_i.addr;
      intr = in_intr(out_addr);
      // any non-legacy table mode is unsupported
      if (!legacy)
         reason = fault_check_pkg::REASON_ROOT_TBL;
      else if (!applicable)
         reason = fault_check_pkg::REASON_NONE;
      else if (ovf)
         reason = fault_check_pkg::REASON_OVERFLOW;
      else if (rsvd)
         reason = fault_check_pkg::REASON_RSVD;
      else if (wfault)
         reason = fault_check_pkg::REASON_NO_WRITE;
      else if (rfault)
         reason = fault_check_pkg::REASON_NO_READ;
      else if (intr)
         reason = fault_check_pkg::REASON_INTR;
      else
         reason = fault_check_pkg::REASON_NONE;
   end

   // response choice from reason and request kind
   always_comb
   begin
      cpl_new.req_id = req_i.req_id;
      cpl_new.reason = reason;
      cpl_new.fault = (reason != fault_check_pkg::REASON_NONE);
      cpl_new.perm_read = walked ? req_i.entry_read : 1'b1;
      cpl_new.perm_write = walked ? req_i.entry_write : 1'b1;
      cpl_new.resp = fault_check_pkg::RESP_SUCCESS;
      case (reason)
         fault_check_pkg::REASON_NONE:
            cpl_new.resp = fault_check_pkg::RESP_SUCCESS;
         fault_check_pkg::REASON_OVERFLOW:
         begin
            cpl_new.perm_read = 1'b0;
            cpl_new.perm_write = 1'b0;
            cpl_new.resp = (req_i.kind == fault_check_pkg::REQ_TRANSLATION)
                           ? fault_check_pkg::RESP_SUCCESS : fault_check_pkg::RESP_UR;
         end
         fault_check_pkg::REASON_NO_WRITE,
         fault_check_pkg::REASON_NO_READ:
            cpl_new.resp = (req_i.kind == fault_check_pkg::REQ_TRANSLATION)
                           ? fault_check_pkg::RESP_SUCCESS : fault_check_pkg::RESP_UR;
         fault_check_pkg::REASON_RSVD,
         fault_check_pkg::REASON_INTR,
         fault_check_pkg::REASON_ROOT_TBL:
            cpl_new.resp = (req_i.kind == fault_check_pkg::REQ_TRANSLATION)
                           ? fault_check_pkg::RESP_CA : fault_check_pkg::RESP_UR;
         default:
            cpl_new.resp = fault_check_pkg::RESP_UR;
      endcase
   end

   assign log_wr = req_valid_i && cpl_new.fault;

   // next-state logic: completion, fault log, registers
   always_comb
   begin
      logic [2:0]  ev;
      logic        hit;
      logic [31:0] ctrl_w;
      ev = '0;
      hit = 1'b0;
      ctrl_w = '0;
      state_next = state_reg;
      // reason and id leave with the status
      state_next.cpl_valid = req_valid_i;
      if (req_valid_i)
      begin
         state_next.cpl = cpl_new;
      end
      if (log_wr)
      begin
         state_next.last_reason = cpl_new.reason;
         state_next.last_id = cpl_new.req_id;
         state_next.fault_cnt = state_reg.fault_cnt + 16'h0001;
         state_next.log_head = state_reg.log_head + LOG_AW'(1);
      end
      ev[fault_check_pkg::IRQ_FAULT] = log_wr;
      ev[fault_check_pkg::IRQ_UR] = req_valid_i && (cpl_new.resp == fault_check_pkg::RESP_UR);
      ev[fault_check_pkg::IRQ_CA] = req_valid_i && (cpl_new.resp == fault_check_pkg::RESP_CA);
      // ack for one cycle, then drop while master releases
      hit = wb_cyc_i && wb_stb_i && !state_reg.ack;
      state_next.ack = hit;
      state_next.dat = '0;
      if (hit && wb_we_i)
      begin
         case (wb_adr_i)
            fault_check_pkg::OFS_CTRL:
            begin
               ctrl_w = merge({30'h0, state_reg.translation_table_mode}, wb_dat_i, wb_sel_i);
               state_next.translation_table_mode = ctrl_w[fault_check_pkg::CTRL_TTM_LSB +: 2];
               if (wb_sel_i[1])
                  state_next.max_guest_address_width = wb_dat_i[fault_check_pkg::CTRL_MAX_GUEST_ADDRESS_WIDTH_LSB +: W];
               if (wb_sel_i[2])
                  state_next.host_address_width = wb_dat_i[fault_check_pkg::CTRL_HAW_LSB +: W];
            end
            fault_check_pkg::OFS_IRQ_CLR:
               if (wb_sel_i[0])
                  state_next.irq_stat = state_reg.irq_stat & ~wb_dat_i[2:0];
            fault_check_pkg::OFS_IRQ_EN:
               if (wb_sel_i[0])
                  state_next.irq_en = wb_dat_i[2:0];
            fault_check_pkg::OFS_LOG_IDX:
               if (wb_sel_i[0])
                  state_next.log_idx = wb_dat_i[LOG_AW-1:0];
            default:
               state_next.dat = '0;
         endcase
      end
      else if (hit)
      begin
         case (wb_adr_i)
            fault_check_pkg::OFS_CTRL:
            begin
               state_next.dat[fault_check_pkg::CTRL_TTM_LSB +: 2] = state_reg.translation_table_mode;
               state_next.dat[fault_check_pkg::CTRL_ZLR_BIT] = ZLR_CAP;
               state_next.dat[fault_check_pkg::CTRL_MAX_GUEST_ADDRESS_WIDTH_LSB +: W] = state_reg.max_guest_address_width;
               state_next.dat[fault_check_pkg::CTRL_HAW_LSB +: W] = state_reg.host_address_width;
            end
            fault_check_pkg::OFS_IRQ_STAT:
               state_next.dat[2:0] = state_reg.irq_stat;
            fault_check_pkg::OFS_IRQ_EN:
               state_next.dat[2:0] = state_reg.irq_en;
            fault_check_pkg::OFS_LAST:
            begin
               state_next.dat[7:0] = state_reg.last_reason;
               state_next.dat[fault_check_pkg::LAST_ID_LSB +: 16] = state_reg.last_id;
            end
            fault_check_pkg::OFS_COUNT:
               state_next.dat[15:0] = state_reg.fault_cnt;
            fault_check_pkg::OFS_LOG_IDX:
               state_next.dat[LOG_AW-1:0] = state_reg.log_idx;
            fault_check_pkg::OFS_LOG_DATA:
               state_next.dat[LOG_W-1:0] = log_rd_data;
            default:
               state_next.dat = '0;
         endcase
      end
      // new events win over a clear in the same cycle
      state_next.irq_stat = state_next.irq_stat | ev;
   end

   // state register
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_reg <= '0;
         state_reg.max_guest_address_width <= fault_check_pkg::MAX_GUEST_ADDRESS_WIDTH_RESET;
         state_reg.host_address_width <= fault_check_pkg::HAW_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // fault log, head advances on each fault
   fault_log_mem #(
      .DEPTH     (LOG_DEPTH),
      .WIDTH     (LOG_W)
   ) u_log (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .wr_en_i   (log_wr),
      .wr_addr_i (state_reg.log_head),
      .wr_data_i ({cpl_new.req_id, cpl_new.reason}),
      .rd_addr_i (state_reg.log_idx),
      .rd_data_o (log_rd_data)
   );

   // outputs straight from state
   assign cpl_valid_o = state_reg.cpl_valid;
   assign cpl_o = state_reg.cpl;
   assign wb_ack_o = state_reg.ack;
   assign wb_dat_o = state_reg.dat;
   assign irq_o = |(state_reg.irq_stat & state_reg.irq_en);

   // checks on the issued completions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_legacy_walk;
      req_valid_i && legacy && !req_i.has_pasid && walked;
   endsequence

   a_reserved_entry: assert property (
      s_legacy_walk ##0 (req_i.entry_rsvd_nonzero && req_i.entry_read && !ovf)
      |=> cpl_o.reason == fault_check_pkg::REASON_RSVD && cpl_o.resp != fault_check_pkg::RESP_SUCCESS)
      else $error("reserved entry not flagged");

   a_guest_overflow: assert property (
      s_legacy_walk ##0 above_width(req_i.addr, guest_w)
      ##1 cpl_valid_o |-> cpl_o.reason == fault_check_pkg::REASON_OVERFLOW
      && !cpl_o.perm_read && !cpl_o.perm_write)
      else $error("guest overflow not flagged");

   a_translated_ovf: assert property (
      req_valid_i && legacy && req_i.kind == fault_check_pkg::REQ_TRANSLATED
      && above_width(req_i.addr, state_reg.host_address_width)
      |=> cpl_o.resp == fault_check_pkg::RESP_UR && cpl_o.reason == fault_check_pkg::REASON_OVERFLOW)
      else $error("translated overflow not flagged");

   a_pass_ovf: assert property (
      req_valid_i && legacy && pass && !req_i.has_pasid && above_width(req_i.addr, state_reg.host_address_width)
      |=> cpl_o.resp == fault_check_pkg::RESP_UR && cpl_o.reason == fault_check_pkg::REASON_OVERFLOW)
      else $error("pass-through overflow not flagged");

   a_no_write: assert property (
      s_legacy_walk ##0 (!ovf && !rsvd && req_i.is_write && !req_i.entry_write)
      |=> cpl_o.reason == fault_check_pkg::REASON_NO_WRITE && cpl_o.fault)
      else $error("write fault missed");

   a_zlr_excuse: assert property (
      s_legacy_walk ##0 (zlr_excuse && !ovf && !rsvd && !intr)
      |=> !cpl_o.fault && cpl_o.resp == fault_check_pkg::RESP_SUCCESS)
      else $error("zero-length read faulted");

   a_intr_range: assert property (
      req_valid_i && legacy && req_i.kind == fault_check_pkg::REQ_TRANSLATED
      && in_intr(req_i.addr) && !above_width(req_i.addr, state_reg.host_address_width)
      |=> cpl_o.reason == fault_check_pkg::REASON_INTR)
      else $error("interrupt range missed");

   a_root_mode: assert property (
      req_valid_i && !legacy |=> cpl_o.reason == fault_check_pkg::REASON_ROOT_TBL)
      else $error("root table fault missed");

   a_pasid_skip: assert property (
      req_valid_i && legacy && req_i.has_pasid && req_i.kind != fault_check_pkg::REQ_TRANSLATED
      |=> !cpl_o.fault)
      else $error("pasid request faulted");

   a_record_pair: assert property (
      req_valid_i && cpl_new.fault
      |=> cpl_valid_o && cpl_o.fault && cpl_o.req_id == $past(req_i.req_id)
      && state_reg.last_id == cpl_o.req_id && state_reg.last_reason == cpl_o.reason)
      else $error("fault record out of step");

endmodule // legacy_second_stage_fault_checker
`default_nettype wire

/* File: verif/req_source.sv */
// request source standing in for the devices that issue dma requests
`default_nettype none
module req_source (
   // clock
   input  wire logic                  clk_i,
   // from the bench
   input  wire logic                  go_i,
   input  wire fault_check_pkg::req_s req_i,
   // towards the checker
   output logic                       req_valid_o,
   output fault_check_pkg::req_s      req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle cycles scramble the fields so stale data never looks like a request
   always_ff @(posedge clk_i)
   begin
      req_valid_o <= go_i;
      req_o       <= go_i ? req_i : ~req_o;
   end
endmodule // req_source
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the legacy second-stage fault checker
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, reset_n = 1'b0, go = 1'b0, vld_q = 1'b0;
   logic        req_valid, cpl_valid, irq, wb_ack;
   logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, rd, last_exp = 32'h0;
   logic [2:0]  stat_exp = 3'h0;
   logic [6:0]  gw = 7'h30, hw = 7'h30;
   logic [1:0]  mode = 2'h0;
   logic [15:0] cfg [6] = '{16'h4fb0, 16'h8ab0, 16'hcfb0, 16'h13bf, 16'h1240, 16'h0c30};
   int          n_mismatch = 0, comparisons = 0, n_fault = 0;
   fault_check_pkg::req_s src_req = '0, req, r;
   fault_check_pkg::cpl_s cpl, e;
   fault_check_pkg::cpl_s exp_q [$];

   // 25 mhz clock
   always #20 clk = ~clk;

   req_source i_src (.clk_i(clk), .go_i(go), .req_i(src_req), .req_valid_o(req_valid),
      .req_o(req));

   legacy_second_stage_fault_checker #(.LOG_DEPTH(4), .ZLR_CAP(1'b1)) i_dut (
      .clk_i(clk), .reset_n_i(reset_n), .req_valid_i(req_valid), .req_i(req),
      .cpl_valid_o(cpl_valid), .cpl_o(cpl), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // classic single cycle; waits up to 50 cycles for ack, then records a failed check
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      do
      begin
         @(negedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      q = wb_rdat;
      if (n >= 50)
         check(1'b0, 1'b1);
      // hold the request through the edge that samples ack high
      @(posedge clk);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk);
   endtask

   // expected completion from the current mode and widths
   function automatic fault_check_pkg::cpl_s model(input fault_check_pkg::req_s q);
      fault_check_pkg::cpl_s c;
      logic tr, walk;
      int x, cw;
      c = '0;
      c.req_id = q.req_id;
      tr = (q.kind == fault_check_pkg::REQ_TRANSLATION);
      walk = tr || (q.kind == fault_check_pkg::REQ_UNTRANSLATED && q.translation_type_field != 2'h2);
      cw = q.context_address_width_field;
      x = walk ? (gw < cw ? gw : cw) : hw;
      if (mode != 2'h0)
         c.reason = 8'h30;
      else if (q.has_pasid && q.kind != fault_check_pkg::REQ_TRANSLATED)
         c.reason = 8'h00;
      else if (x < 64 && (q.addr >> x) != 64'h0)
         c.reason = 8'h04;
      else if (walk && q.entry_rsvd_nonzero && (q.entry_read || q.entry_write))
         c.reason = 8'h0c;
      else if (walk && (q.is_write || q.is_atomic) && !q.entry_write)
         c.reason = 8'h05;
      else if (walk && (q.is_read || q.is_atomic) && !q.entry_read
               && !(q.zero_length && q.entry_write && !q.is_atomic))
         c.reason = 8'h06;
      else if ((walk ? q.remap_addr[63:20] : q.addr[63:20]) == 44'h00000000fee)
         c.reason = 8'h0e;
      c.fault = (c.reason != 8'h00);
      c.perm_read = walk ? q.entry_read : 1'b1;
      c.perm_write = walk ? q.entry_write : 1'b1;
      if (c.reason == 8'h04)
         {c.perm_read, c.perm_write} = 2'b00;
      c.resp = !c.fault || (tr && c.reason inside {8'h04, 8'h05, 8'h06}) ?
         fault_check_pkg::RESP_SUCCESS : tr ? fault_check_pkg::RESP_CA : fault_check_pkg::RESP_UR;
      return c;
   endfunction

   function automatic logic [63:0] pick_addr();
      case ($urandom_range(3))
         0: return {32'h0, $urandom()};
         1: return {44'h00000000fee, 20'($urandom())};
         2: return 64'h1 << $urandom_range(63);
         default: return {$urandom(), $urandom()};
      endcase
   endfunction

   function automatic fault_check_pkg::req_s rand_req();
      fault_check_pkg::req_s q;
      q = $bits(q)'({$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()});
      q.kind = fault_check_pkg::req_kind_e'($urandom_range(2));
      q.has_pasid = ($urandom_range(3) == 0);
      q.entry_rsvd_nonzero = ($urandom_range(5) == 0);
      q.context_address_width_field = 7'($urandom_range(30, 70));
      q.addr = pick_addr();
      q.remap_addr = pick_addr();
      return q;
   endfunction

   // queue the expectation, then present the request for one cycle
   task automatic send(input fault_check_pkg::req_s q);
      fault_check_pkg::cpl_s c;
      c = model(q);
      exp_q.push_back(c);
      stat_exp |= {c.resp == fault_check_pkg::RESP_CA, c.resp == fault_check_pkg::RESP_UR, c.fault};
      n_fault += c.fault;
      if (c.fault)
         last_exp = {c.req_id, 8'h00, c.reason};
      go <= 1'b1;
      src_req <= q;
      @(posedge clk);
   endtask

   // completion monitor at the falling edge, where registered outputs are settled
   always @(negedge clk)
   begin
      if (reset_n)
      begin
         check(cpl_valid, vld_q);
         if (cpl_valid === 1'b1)
         begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
            check(cpl.req_id, e.req_id);
            check(cpl.reason, e.reason);
            check({cpl.resp, cpl.fault}, {e.resp, e.fault});
            if (e.resp == fault_check_pkg::RESP_SUCCESS)
               check({cpl.perm_read, cpl.perm_write}, {e.perm_read, e.perm_write});
         end
      end
      vld_q <= req_valid;
   end

   // watchdog sized well above the expected run length
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(32'h58c98139));
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, 8'h00, 32'h0, rd);
      check(rd, 32'h00303004);
      for (int k = 0; k < 6; k++)
      begin
         {mode, gw, hw} = cfg[k];
         wb(1'b1, 8'h00, {9'h0, hw, 1'b0, gw, 6'h0, mode}, rd);
         wb(1'b0, 8'h00, 32'h0, rd);
         check(rd, {9'h0, hw, 1'b0, gw, 5'h0, 1'b1, mode});
         for (int n = 0; n < (k < 3 ? 6 : 70); n++)
            send(rand_req());
         go <= 1'b0;
         repeat (3) @(posedge clk);
      end
      // zero-length read to a write-only page, then the same as an atomic
      r = rand_req();
      r.kind = fault_check_pkg::REQ_UNTRANSLATED;
      {r.has_pasid, r.translation_type_field} = 3'h0;
      {r.addr, r.remap_addr} = {64'h1000, 64'h2000};
      {r.entry_rsvd_nonzero, r.entry_read, r.entry_write} = 3'b001;
      {r.is_read, r.is_write, r.is_atomic, r.zero_length} = 4'b1001;
      send(r);
      r.is_atomic = 1'b1;
      send(r);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0, rd);
      check({rd, irq}, {29'h0, stat_exp, 1'b0});
      wb(1'b0, 8'h14, 32'h0, rd);
      check(rd[15:0], 16'(n_fault));
      wb(1'b0, 8'h10, 32'h0, rd);
      check(rd, last_exp);
      // newest log entry sits just below the head; bench log is four deep
      wb(1'b1, 8'h18, 32'((n_fault - 1) % 4), rd);
      wb(1'b0, 8'h1c, 32'h0, rd);
      check(rd, {8'h0, last_exp[31:16], last_exp[7:0]});
      check(exp_q.size(), 0);
      wb(1'b1, 8'h0c, 32'h1, rd);
      check(irq, 1'b1);
      // clearing the only enabled bit drops the line, others stay sticky
      wb(1'b1, 8'h08, 32'h1, rd);
      check(irq, 1'b0);
      wb(1'b1, 8'h04, 32'h7, rd);
      wb(1'b0, 8'h04, 32'h0, rd);
      check(rd, {29'h0, stat_exp & 3'h6});
      wb(1'b0, 8'h08, 32'h0, rd);
      check(rd, 32'h0);
      wb(1'b0, 8'h40, 32'h0, rd);
      check(rd, 32'h0);
      wb(1'b1, 8'h08, 32'h7, rd);
      wb(1'b0, 8'h04, 32'h0, rd);
      check(rd, 32'h0);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
